/* File: design/flash_overlay_pkg.sv */
// shared constants, register map and types of the flash overlay block
package flash_overlay_pkg;
    // register byte offsets on the Avalon-MM slave
    localparam logic [4:0] OFS_OVERLAY_CTRL = 5'h00;
    localparam logic [4:0] OFS_ERASE_START = 5'h04;
    localparam logic [4:0] OFS_ERASE_RESULT = 5'h08;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h0C;
    localparam logic [4:0] OFS_IRQ_CLEAR = 5'h10;
    localparam logic [4:0] OFS_IRQ_ENABLE = 5'h14;
    localparam logic [4:0] OFS_MODE_STATUS = 5'h18;
    // ram_overlay_control layout
    localparam logic [7:0] OVERLAY_CTRL_RESET = 8'h00;
    localparam logic [7:0] OVERLAY_CTRL_RW_MASK = 8'h1F;
    localparam int CTRL_RSVD4_BIT = 4;
    localparam int CTRL_ENABLE_BIT = 3;
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_SEL_W = 3;
    // erase_result_parameter layout
    localparam int RESULT_RANGE_BIT = 3;
    localparam int RESULT_FAIL_BIT = 0;
    // interrupt bits
    localparam int IRQ_W = 2;
    localparam int IRQ_ERASE_DONE = 0;
    localparam int IRQ_ERASE_FAIL = 1;
    localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 2'h0;
    // mode status bits
    localparam int MODE_HW_STANDBY_BIT = 0;
    localparam int MODE_SW_STANDBY_BIT = 1;
    localparam int MODE_WATCH_BIT = 2;
    localparam int MODE_ERASE_BUSY_BIT = 3;
    localparam int MODE_OVERLAY_BIT = 4;
    // memory map
    localparam logic [23:0] RAM_WINDOW_BASE = 24'hFFD000;
    localparam int BLOCK_ADDR_W = 12;
    localparam int USER_MAT_BLOCKS = 16;
    // erase duration of the modelled flash array
    localparam int CLK_PERIOD_NS = 100;
    localparam int ERASE_TIME_NS = 10000;
    localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic valid;
        logic write;
        logic [23:0] addr;
    } mem_req_t;

    typedef struct packed {
        logic ram_sel;
        logic flash_sel;
        logic flash_write_ok;
        logic [BLOCK_ADDR_W-1:0] ram_addr;
        logic [23:0] flash_addr;
    } mem_route_t;

    typedef struct packed {
        logic range_error;
        logic fail;
    } erase_result_t;

    typedef enum logic [1:0] {
        ER_IDLE = 2'b00,
        ER_RUN = 2'b01,
        ER_DONE = 2'b10
    } erase_state_t;
endpackage

/* File: design/erase_sequencer.sv */
// erase sequencer: range check, protection check, timed erase and result
`timescale 1ns/10ps
module erase_sequencer
    import flash_overlay_pkg::*;
#(
    parameter int NUM_BLOCKS = USER_MAT_BLOCKS,
    parameter int ERASE_LEN = ERASE_CYCLES
)
(
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic start, // one-cycle erase request
    input wire logic [7:0] block_num, // requested erase block
    input wire logic protect, // user MAT protected
    input wire logic flash_fail, // array reports an erase error
    output logic busy_reg, // erase in progress
    output logic done_reg, // one-cycle completion pulse
    output erase_result_t result_reg, // final result flags
    output logic flash_go_reg, // one-cycle start to the array
    output logic [7:0] flash_block_reg // block given to the array
);
    erase_state_t state_reg;
    logic [15:0] count_reg;
    logic fail_seen_reg;
    wire range_bad = ({24'h0, block_num} >= NUM_BLOCKS);
    wire accept = (state_reg == ER_IDLE) && start;
    wire refuse = range_bad || protect;
    wire run_end = (state_reg == ER_RUN) && (count_reg == 16'h0000);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= ER_IDLE;
            count_reg <= 16'h0000;
            fail_seen_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            result_reg <= '0;
            flash_go_reg <= 1'b0;
            flash_block_reg <= 8'h00;
        end
        else
        begin
            done_reg <= 1'b0;
            flash_go_reg <= 1'b0;
            case (state_reg)
                ER_IDLE:
                begin
                    if (accept && refuse)
                    begin
                        result_reg.range_error <= range_bad;
                        result_reg.fail <= 1'b1;
                        state_reg <= ER_DONE;
                        done_reg <= 1'b1;
                    end
                    else if (accept)
                    begin
                        result_reg.range_error <= 1'b0;
                        flash_go_reg <= 1'b1;
                        flash_block_reg <= block_num;
                        count_reg <= 16'(ERASE_LEN - 1);
                        fail_seen_reg <= 1'b0;
                        busy_reg <= 1'b1;
                        state_reg <= ER_RUN;
                    end
                end
                ER_RUN:
                begin
                    fail_seen_reg <= fail_seen_reg | flash_fail;
                    if (run_end)
                    begin
                        result_reg.fail <= fail_seen_reg | flash_fail;
                        busy_reg <= 1'b0;
                        done_reg <= 1'b1;
                        state_reg <= ER_DONE;
                    end
                    else
                    begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end
                ER_DONE:
                begin
                    state_reg <= ER_IDLE;
                end
                default:
                begin
                    state_reg <= ER_IDLE;
                end
            endcase
        end
    end

    chk_range_flag: assert property (@(posedge clk) disable iff (rst)
        accept && range_bad |=> done_reg && result_reg.range_error && result_reg.fail)
        else $error("range error not flagged");
    chk_protect_fail: assert property (@(posedge clk) disable iff (rst)
        accept && protect |=> done_reg && result_reg.fail && !busy_reg)
        else $error("protected erase not refused");
endmodule

/* File: design/overlay_router.sv */
// address router that lays the ram window over one user MAT block
`timescale 1ns/10ps
module overlay_router
    import flash_overlay_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input mem_req_t req, // cpu memory access
    input wire logic overlay_on, // overlay enable bit
    input wire logic [CTRL_SEL_W-1:0] block_sel, // selected block
    output mem_route_t route_reg // registered routing decision
);
    wire [23:0] block_base = {{(24-BLOCK_ADDR_W-CTRL_SEL_W){1'b0}}, block_sel, {BLOCK_ADDR_W{1'b0}}};
    wire in_ram_window = req.addr[23:BLOCK_ADDR_W] == RAM_WINDOW_BASE[23:BLOCK_ADDR_W];
    wire in_block = req.addr[23:BLOCK_ADDR_W] == block_base[23:BLOCK_ADDR_W];
    wire hit_overlay = overlay_on && in_block;
    wire to_ram = req.valid && (in_ram_window || hit_overlay);
    wire to_flash = req.valid && !to_ram;
    wire write_ok = req.write && !overlay_on;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            route_reg <= '0;
        end
        else
        begin
            route_reg.ram_sel <= to_ram;
            route_reg.flash_sel <= to_flash;
            route_reg.flash_write_ok <= to_flash && write_ok;
            route_reg.ram_addr <= req.addr[BLOCK_ADDR_W-1:0];
            route_reg.flash_addr <= req.addr;
        end
    end

    chk_overlay_hit: assert property (@(posedge clk) disable iff (rst)
        req.valid && overlay_on && in_block |=> route_reg.ram_sel && !route_reg.flash_sel)
        else $error("overlay block access not sent to ram");
    chk_flash_protect: assert property (@(posedge clk) disable iff (rst)
        overlay_on |=> !route_reg.flash_write_ok)
        else $error("flash write allowed under overlay");
    chk_normal_map: assert property (@(posedge clk) disable iff (rst)
        req.valid && !overlay_on && !in_ram_window |=> route_reg.flash_sel && !route_reg.ram_sel)
        else $error("flash access diverted without overlay");
endmodule

/* File: design/flash_ram_emulation_overlay.sv */
// top of the flash overlay block: register file, interrupts and glue
`timescale 1ns/10ps
// Functional notes
// - erase block number outside user MAT range sets range error, valid clears it
// - erase result bit 0 is zero on success and one on failure
// - overlay control clears to zero on power-on reset or hardware standby
// - overlay control keeps its value through software standby and watch mode
// - bits 7 to 5 of overlay control read zero; software writes zero
// - bit 4 of overlay control is read/write, resets zero, software writes zero
// - overlay enabled turns emulation on and protects the whole user MAT
// - overlay disabled: no protection, select bits ignored, ram at normal place
// - select bits pick 4-kbyte block n at n times 4 kbytes, overlaid by ram
// - selected block address range is served by on-chip ram for emulation
module flash_ram_emulation_overlay
    import flash_overlay_pkg::*;
#(
    parameter int NUM_BLOCKS = USER_MAT_BLOCKS,
    parameter int ERASE_LEN = ERASE_CYCLES
)
(
    input wire logic clk, // 10 MHz system clock
    input wire logic rst, // synchronous power-on reset, active high
    input wire logic [4:0] avs_address, // register byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // slave stall
    input wire logic hw_standby, // hardware standby pin
    input wire logic sw_standby, // software standby pin
    input wire logic watch_mode, // watch mode pin
    input mem_req_t mem_req, // cpu memory access
    output mem_route_t mem_route, // routing to ram or flash
    output logic overlay_active, // emulation on, user MAT protected
    input wire logic flash_erase_fail, // array erase error
    output logic flash_erase_go, // one-cycle erase start to array
    output logic [7:0] flash_erase_block, // block being erased
    output logic irq // level interrupt
);
    // pin synchronisers
    logic [2:0] pins_meta_reg;
    logic [2:0] pins_sync_reg;
    wire [2:0] pins_raw = {watch_mode, sw_standby, hw_standby};
    wire hw_sb = pins_sync_reg[0];
    wire sw_sb = pins_sync_reg[1];
    wire watch = pins_sync_reg[2];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pins_meta_reg <= 3'h0;
            pins_sync_reg <= 3'h0;
        end
        else
        begin
            pins_meta_reg <= pins_raw;
            pins_sync_reg <= pins_meta_reg;
        end
    end

    // Avalon-MM slave: one wait cycle, then the access completes
    logic wait_reg;
    logic [31:0] readdata_reg;
    wire bus_req = avs_read || avs_write;
    wire bus_fire = bus_req && !wait_reg;
    wire wr_fire = bus_fire && avs_write && avs_byteenable[0];
    wire sel_ctrl = avs_address == OFS_OVERLAY_CTRL;
    wire sel_start = avs_address == OFS_ERASE_START;
    wire sel_result = avs_address == OFS_ERASE_RESULT;
    wire sel_status = avs_address == OFS_IRQ_STATUS;
    wire sel_clear = avs_address == OFS_IRQ_CLEAR;
    wire sel_enable = avs_address == OFS_IRQ_ENABLE;
    wire sel_mode = avs_address == OFS_MODE_STATUS;
    wire ctrl_wr = wr_fire && sel_ctrl;
    wire start_wr = wr_fire && sel_start;
    wire clear_wr = wr_fire && sel_clear;
    wire enable_wr = wr_fire && sel_enable;
    wire wr_bit4 = avs_writedata[CTRL_RSVD4_BIT];

    // overlay control register
    logic [7:0] ctrl_reg;
    wire [7:0] ctrl_next = avs_writedata[7:0] & OVERLAY_CTRL_RW_MASK;
    wire ctrl_clear = hw_sb;
    wire overlay_on = ctrl_reg[CTRL_ENABLE_BIT];
    wire [CTRL_SEL_W-1:0] block_sel = ctrl_reg[CTRL_SEL_LSB +: CTRL_SEL_W];

    // software standby and watch leave this register alone by design; hardware standby clears it
    always_ff @(posedge clk)
    begin
        if (rst || ctrl_clear)
        begin
            ctrl_reg <= OVERLAY_CTRL_RESET;
        end
        else if (ctrl_wr)
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // erase request capture
    logic start_reg;
    logic [7:0] start_block_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            start_reg <= 1'b0;
            start_block_reg <= 8'h00;
        end
        else
        begin
            start_reg <= start_wr;
            if (start_wr)
            begin
                start_block_reg <= avs_writedata[7:0];
            end
        end
    end

    logic erase_busy;
    logic erase_done;
    erase_result_t erase_result;

    erase_sequencer #(
        .NUM_BLOCKS(NUM_BLOCKS),
        .ERASE_LEN(ERASE_LEN)
    ) u_erase (
        .clk(clk),
        .rst(rst),
        .start(start_reg),
        .block_num(start_block_reg),
        .protect(overlay_on),
        .flash_fail(flash_erase_fail),
        .busy_reg(erase_busy),
        .done_reg(erase_done),
        .result_reg(erase_result),
        .flash_go_reg(flash_erase_go),
        .flash_block_reg(flash_erase_block)
    );

    // routing is registered, so a new overlay setting reaches
    // the memory path one cycle after the register write
    overlay_router u_router (
        .clk(clk),
        .rst(rst),
        .req(mem_req),
        .overlay_on(overlay_on),
        .block_sel(block_sel),
        .route_reg(mem_route)
    );

    // interrupt status, clear and enable
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_enable_reg;
    logic irq_reg;
    wire [IRQ_W-1:0] irq_event = {erase_done && erase_result.fail, erase_done};
    wire [IRQ_W-1:0] irq_clear = clear_wr ? avs_writedata[IRQ_W-1:0] : {IRQ_W{1'b0}};

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi = gi + 1)
        begin : g_irq
            // an event in the clearing cycle survives the clear
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    irq_status_reg[gi] <= 1'b0;
                end
                else if (irq_event[gi])
                begin
                    irq_status_reg[gi] <= 1'b1;
                end
                else if (irq_clear[gi])
                begin
                    irq_status_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_enable_reg <= IRQ_ENABLE_RESET;
            irq_reg <= 1'b0;
        end
        else
        begin
            if (enable_wr)
            begin
                irq_enable_reg <= avs_writedata[IRQ_W-1:0];
            end
            irq_reg <= |(irq_status_reg & irq_enable_reg);
        end
    end

    // read multiplexer; unmapped and write-only offsets read zero
    wire [31:0] rd_ctrl = {24'h0, 3'b000, ctrl_reg[4:0]};
    wire [31:0] rd_result = {28'h0, erase_result.range_error, 2'b00, erase_result.fail};
    wire [31:0] rd_status = {{(32-IRQ_W){1'b0}}, irq_status_reg};
    wire [31:0] rd_enable = {{(32-IRQ_W){1'b0}}, irq_enable_reg};
    wire [31:0] rd_mode = {27'h0, overlay_on, erase_busy, watch, sw_sb, hw_sb};
    wire [31:0] rd_mux = sel_ctrl ? rd_ctrl :
                         sel_result ? rd_result :
                         sel_status ? rd_status :
                         sel_enable ? rd_enable :
                         sel_mode ? rd_mode : 32'h0000_0000;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wait_reg <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end
        else if (bus_req && wait_reg)
        begin
            wait_reg <= 1'b0;
            if (avs_read)
            begin
                readdata_reg <= rd_mux;
            end
        end
        else
        begin
            wait_reg <= 1'b1;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = readdata_reg;
    assign overlay_active = ctrl_reg[CTRL_ENABLE_BIT];
    assign irq = irq_reg;

    // checks
    chk_standby_clear: assert property (@(posedge clk) disable iff (rst)
        hw_sb |=> ctrl_reg == OVERLAY_CTRL_RESET)
        else $error("hardware standby did not clear overlay control");
    chk_standby_hold: assert property (@(posedge clk) disable iff (rst)
        (sw_sb || watch) && !hw_sb && !ctrl_wr |=> $stable(ctrl_reg))
        else $error("overlay control changed in standby or watch");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        avs_read && wait_reg && sel_ctrl |=> readdata_reg[7:5] == 3'b000 && ctrl_reg[7:5] == 3'b000)
        else $error("reserved overlay bits not zero");
    chk_bit4_rw: assert property (@(posedge clk) disable iff (rst)
        ctrl_wr && !hw_sb |=> ctrl_reg[CTRL_RSVD4_BIT] == $past(wr_bit4))
        else $error("bit 4 of overlay control not writable");
    chk_result_read: assert property (@(posedge clk) disable iff (rst)
        avs_read && wait_reg && sel_result |=>
        readdata_reg[RESULT_FAIL_BIT] == $past(erase_result.fail) &&
        readdata_reg[RESULT_RANGE_BIT] == $past(erase_result.range_error))
        else $error("erase result read mismatch");
    chk_bus_answer: assert property (@(posedge clk) disable iff (rst)
        bus_req && wait_reg |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    chk_irq_level: assert property (@(posedge clk) disable iff (rst)
        |(irq_status_reg & irq_enable_reg) |=> irq)
        else $error("enabled status did not raise interrupt");
    chk_erase_done: assert property (@(posedge clk) disable iff (rst)
        erase_done |-> ##[1:2] irq_status_reg[IRQ_ERASE_DONE])
        else $error("erase completion not recorded");
    chk_protect_out: assert property (@(posedge clk) disable iff (rst)
        ctrl_wr && !hw_sb && avs_writedata[CTRL_ENABLE_BIT] |=> overlay_active)
        else $error("overlay enable write not taken");
endmodule

/* File: tb/tb.sv */
// self-checking bench for the flash ram emulation overlay block
`timescale 1ns/10ps
module tb;
    import flash_overlay_pkg::*;
    localparam int ELEN = 4;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic clk;
    logic rst;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic hw_standby;
    logic sw_standby;
    logic watch_mode;
    mem_req_t mem_req;
    mem_route_t mem_route;
    logic overlay_active;
    logic flash_erase_fail;
    logic flash_erase_go;
    logic [7:0] flash_erase_block;
    logic irq;
    int fail_count;
    int samples_checked;
    int go_count;
    logic [7:0] go_block;
    logic route_pending;
    logic [63:0] rd_q[$];
    logic [38:0] rt_q[$];
    logic [63:0] e;
    logic [31:0] rdata;
    logic [11:0] ofs;

    flash_ram_emulation_overlay #(.NUM_BLOCKS(USER_MAT_BLOCKS), .ERASE_LEN(ELEN)) dut_u (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hw_standby(hw_standby), .sw_standby(sw_standby),
        .watch_mode(watch_mode), .mem_req(mem_req), .mem_route(mem_route), .overlay_active(overlay_active),
        .flash_erase_fail(flash_erase_fail), .flash_erase_go(flash_erase_go),
        .flash_erase_block(flash_erase_block), .irq(irq));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_route(input logic [38:0] exp, input mem_route_t got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] mem_route expected %h seen %h", exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one Avalon-MM cycle; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] wd, input logic [3:0] be);
        int n;
        @(posedge clk);
        avs_address <= ad;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            $display("[ERR] waitrequest expected 0 seen 1");
            fail_count++;
            end_of_test();
        end
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] ad, input logic [31:0] exp, input logic [31:0] mask);
        rd_q.push_back({mask, exp});
        bus(1'b0, ad, 32'h0, 4'hF);
    endtask

    // one cpu write access; expectation noted before driving
    task automatic mem(input logic [23:0] ad, input logic on, input logic [2:0] sel);
        logic r;
        r = (ad[23:12] == RAM_WINDOW_BASE[23:12]) || (on && ad[23:12] == {9'h0, sel});
        rt_q.push_back({r, !r, !r && !on, ad[11:0], ad});
        @(posedge clk);
        mem_req <= '{valid: 1'b1, write: 1'b1, addr: ad};
        @(posedge clk);
        mem_req.valid <= 1'b0;
    endtask

    task automatic erase(input logic [7:0] b, input logic fl, input logic on);
        int g;
        int n;
        logic bad;
        g = go_count;
        bad = b >= USER_MAT_BLOCKS;
        flash_erase_fail <= fl;
        bus(1'b1, OFS_ERASE_START, {24'h0, b}, 4'hF);
        repeat (3) @(posedge clk);
        n = 0;
        do
        begin
            rd(OFS_MODE_STATUS, 32'h0, 32'h0);
            n++;
        end
        while (rdata[MODE_ERASE_BUSY_BIT] !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            $display("[ERR] erase_busy expected 0 seen 1");
            fail_count++;
            end_of_test();
        end
        chk("erase_go_count", g + ((bad || on) ? 0 : 1), go_count);
        if (!bad && !on)
            chk("erase_block", {24'h0, b}, {24'h0, go_block});
        rd(OFS_ERASE_RESULT, {28'h0, bad, 2'b0, bad | on | fl}, 32'hFF);
    endtask

    // watches read answers, routing results and erase starts
    always @(posedge clk)
    begin
        if (avs_read && avs_waitrequest === 1'b0 && rd_q.size() > 0)
        begin
            e = rd_q.pop_front();
            if (e[63:32] != 32'h0)
                chk("readdata", e[31:0] & e[63:32], avs_readdata & e[63:32]);
        end
        if (route_pending && rt_q.size() > 0)
            chk_route(rt_q.pop_front(), mem_route);
        route_pending <= mem_req.valid;
        if (flash_erase_go === 1'b1)
        begin
            go_count++;
            go_block = flash_erase_block;
        end
    end

    initial
    begin
        rst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
        {hw_standby, sw_standby, watch_mode, flash_erase_fail, route_pending} = '0;
        mem_req = '0;
        fail_count = 0;
        samples_checked = 0;
        go_count = 0;
        go_block = 8'h00;
        void'($urandom(32'h3d329972));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_OVERLAY_CTRL, 32'h00, ALL);
        rd(OFS_IRQ_ENABLE, 32'h00, ALL);
        bus(1'b1, OFS_OVERLAY_CTRL, 32'hFF, 4'hF);
        rd(OFS_OVERLAY_CTRL, 32'h1F, ALL);
        bus(1'b1, OFS_OVERLAY_CTRL, 32'h00, 4'hE);
        rd(OFS_OVERLAY_CTRL, 32'h1F, ALL);
        rd(5'h1C, 32'h00, ALL);
        for (int n = 0; n < 8; n++)
        begin
            ofs = 12'($urandom_range(4095));
            bus(1'b1, OFS_OVERLAY_CTRL, 32'h08 | n, 4'hF);
            repeat (2) @(posedge clk);
            chk("overlay_active", 32'h1, {31'h0, overlay_active});
            mem({9'h0, n[2:0], ofs}, 1'b1, n[2:0]);
            mem({9'h0, n[2:0] + 3'h1, ofs}, 1'b1, n[2:0]);
            mem({12'hFFD, ofs}, 1'b1, n[2:0]);
            bus(1'b1, OFS_OVERLAY_CTRL, n, 4'hF);
            repeat (2) @(posedge clk);
            chk("overlay_active", 32'h0, {31'h0, overlay_active});
            mem({9'h0, n[2:0], ofs}, 1'b0, n[2:0]);
            mem({12'hFFD, ofs}, 1'b0, n[2:0]);
        end
        bus(1'b1, OFS_IRQ_ENABLE, 32'h3, 4'hF);
        erase(8'd2, 1'b0, 1'b0);
        rd(OFS_IRQ_STATUS, 32'h1, ALL);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, OFS_IRQ_ENABLE, 32'h0, 4'hF);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, OFS_IRQ_ENABLE, 32'h3, 4'hF);
        bus(1'b1, OFS_IRQ_CLEAR, 32'h3, 4'hF);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        rd(OFS_IRQ_STATUS, 32'h0, ALL);
        erase(8'd15, 1'b1, 1'b0);
        rd(OFS_IRQ_STATUS, 32'h3, ALL);
        erase(8'd16, 1'b0, 1'b0);
        erase(8'hFF, 1'b0, 1'b0);
        for (int n = 0; n < 4; n++)
            erase(8'($urandom_range(15)), 1'($urandom_range(1)), 1'b0);
        bus(1'b1, OFS_OVERLAY_CTRL, 32'h0B, 4'hF);
        erase(8'd3, 1'b0, 1'b1);
        bus(1'b1, OFS_OVERLAY_CTRL, 32'h0D, 4'hF);
        sw_standby <= 1'b1;
        watch_mode <= 1'b1;
        repeat (6) @(posedge clk);
        rd(OFS_OVERLAY_CTRL, 32'h0D, ALL);
        rd(OFS_MODE_STATUS, 32'h16, 32'h1F);
        sw_standby <= 1'b0;
        watch_mode <= 1'b0;
        hw_standby <= 1'b1;
        repeat (6) @(posedge clk);
        bus(1'b1, OFS_OVERLAY_CTRL, 32'h0A, 4'hF);
        rd(OFS_OVERLAY_CTRL, 32'h00, ALL);
        chk("overlay_active", 32'h0, {31'h0, overlay_active});
        rd(OFS_MODE_STATUS, 32'h01, 32'h1F);
        hw_standby <= 1'b0;
        repeat (6) @(posedge clk);
        rd(OFS_OVERLAY_CTRL, 32'h00, ALL);
        bus(1'b1, OFS_OVERLAY_CTRL, 32'h0D, 4'hF);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_OVERLAY_CTRL, 32'h00, ALL);
        end_of_test();
    end
endmodule
